// [design/legacy_compat_io_mapping.sv]
`timescale 1ns/1ps
module legacy_compat_io_mapping (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic mode_select_switch_a,
   input wire logic mode_select_switch_b,
   input wire logic mode_select_switch_d,
   input wire logic [8:0] input_terminals,
   input wire logic protect_active,
   input wire logic busy_in,
   input wire logic torque_reached_in,
   input wire logic fault_code_pulse_in,
   input wire logic encoder_a_in,
   input wire logic encoder_b_in,
   input wire logic [11:0] speed_pot_wiper_rpm,
   input wire logic [8:0] ramp_pot_tenths,
   output legacy_io_pkg::mode_t active_mode,
   output logic forward_run_input,
   output logic reverse_run_input,
   output logic positioning_start,
   output logic mechanical_origin_sensor,
   output logic [2:0] data_select,
   output logic current_cutoff,
   output logic quick_halt,
   output logic alarm_clear_input,
   output logic aux_input_7,
   output logic aux_input_8,
   output logic stop_hold,
   output legacy_io_pkg::cmd_t motion_cmd,
   output logic output_terminal_0,
   output logic output_terminal_1,
   output logic output_terminal_2,
   output logic encoder_phase_a_output,
   output logic encoder_phase_b_output,
   output logic irq
);
   import legacy_io_pkg::*;

   logic captured; // Mode has been taken since reset
   cfg_t cfg; // Software configuration
   logic [11:0] dig_speed; // Digital speed setpoint
   logic [8:0] dig_ramp; // Digital ramp time
   logic [7:0] dig_torque; // Torque limit
   logic [IRQ_W-1:0] irq_stat; // Sticky events
   logic [IRQ_W-1:0] irq_mask; // Event enables
   logic wr_pend; // Write data phase pending
   logic [7:0] wr_addr; // Address of pending write
   logic prot_d; // Protection seen last cycle
   logic in6_d; // Terminal 6 seen last cycle
   logic [31:0] rd_val; // Read mux result
   logic rej; // Out-of-range write this cycle
   logic [IRQ_W-1:0] next_irq_set; // Events this cycle
   logic [11:0] ana_speed; // Analog speed after limits
   logic [8:0] ana_ramp; // Analog ramp after limits

   // Bus request decode; everything above the map is unmapped
   wire addr_ok = hsel && hready && htrans[1];
   wire map_ok = (haddr[31:5] == 27'h0);
   wire rd_hit = addr_ok && !hwrite && map_ok;
   wire stat_rd = rd_hit && (haddr[7:0] == OFS_IRQ_STAT);

   // Zero wait states, always OKAY
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hreadyout <= 1'b0;
         hresp <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // Address phase of a write is held until its data arrive
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end
      else
      begin
         wr_pend <= addr_ok && hwrite && map_ok;
         if (addr_ok)
            wr_addr <= haddr[7:0];
      end
   end

   // Read mux; the status read sees the value before its clear
   always_comb
   begin
      case (haddr[7:0])
         OFS_MODE: rd_val = 32'(active_mode);
         OFS_CFG: rd_val = 32'(cfg);
         OFS_SPEED: rd_val = 32'(dig_speed);
         OFS_RAMP: rd_val = 32'(dig_ramp);
         OFS_TORQUE: rd_val = 32'(dig_torque);
         OFS_IRQ_STAT: rd_val = 32'(irq_stat);
         OFS_IRQ_MASK: rd_val = 32'(irq_mask);
         OFS_INPUTS: rd_val = 32'(input_terminals);
         default: rd_val = 32'h0000_0000;
      endcase
   end

   // Read data registered at the address edge, zero otherwise
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (rd_hit)
         hrdata <= rd_val;
      else
         hrdata <= 32'h0000_0000;
   end

   // Setpoint writes beyond their range are dropped and flagged
   always_comb
   begin
      rej = 1'b0;
      if (wr_pend)
      begin
         case (wr_addr)
            OFS_SPEED: rej = hwdata > 32'(SPEED_DIG_MAX);
            OFS_RAMP: rej = hwdata > 32'(RAMP_DIG_MAX);
            OFS_TORQUE: rej = hwdata > 32'(TORQUE_MAX);
            default: rej = 1'b0;
         endcase
      end
   end

   // Configuration and digital operation data
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cfg <= cfg_t'(CFG_RST);
         dig_speed <= SPEED_RST;
         dig_ramp <= RAMP_RST;
         dig_torque <= TORQUE_RST;
         irq_mask <= MASK_RST;
      end
      else if (wr_pend && !rej)
      begin
         case (wr_addr)
            OFS_CFG: cfg <= cfg_t'(hwdata[5:0]);
            OFS_SPEED: dig_speed <= hwdata[11:0];
            OFS_RAMP: dig_ramp <= hwdata[8:0];
            OFS_TORQUE: dig_torque <= hwdata[7:0];
            OFS_IRQ_MASK: irq_mask <= hwdata[IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   // mode captured once, never re-read
   // Sampling at the first edge after release keeps reset constant
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         captured <= 1'b0;
         active_mode <= MODE_NONE;
      end
      else if (!captured)
      begin
         captured <= 1'b1;
         if (!mode_select_switch_a && mode_select_switch_b &&
             mode_select_switch_d)
            active_mode <= MODE_SPEED;
         else if (mode_select_switch_a && mode_select_switch_b &&
                  mode_select_switch_d)
            active_mode <= MODE_POS;
         else
            active_mode <= MODE_NONE;
      end
   end

   // Analog limits: below 30 r/min counts as stop
   always_comb
   begin
      if (speed_pot_wiper_rpm < SPEED_ANA_MIN)
         ana_speed = 12'h000;
      else if (speed_pot_wiper_rpm > SPEED_ANA_MAX)
         ana_speed = SPEED_ANA_MAX;
      else
         ana_speed = speed_pot_wiper_rpm;
      if (ramp_pot_tenths < RAMP_ANA_MIN)
         ana_ramp = RAMP_ANA_MIN;
      else if (ramp_pot_tenths > RAMP_ANA_MAX)
         ana_ramp = RAMP_ANA_MAX;
      else
         ana_ramp = ramp_pot_tenths;
   end

   // Motion command; data numbers 0 and 1 follow the pot in speed mode
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         motion_cmd <= '0;
         stop_hold <= STOP_FREE;
      end
      else
      begin
         if (active_mode == MODE_SPEED && input_terminals[4:3] == 2'b00)
         begin
            motion_cmd.speed <= ana_speed;
            motion_cmd.ramp <= ana_ramp;
         end
         else
         begin
            motion_cmd.speed <= dig_speed;
            motion_cmd.ramp <= dig_ramp;
         end
         motion_cmd.torque <= dig_torque;
         stop_hold <= (active_mode == MODE_SPEED) ? cfg.stop_hold :
                      STOP_FREE;
      end
   end

   // Terminal functions per mode; with no mode only aux inputs 7 and 8 are driven
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         forward_run_input <= 1'b0;
         reverse_run_input <= 1'b0;
         positioning_start <= 1'b0;
         mechanical_origin_sensor <= 1'b0;
         data_select <= 3'h0;
         current_cutoff <= 1'b0;
         quick_halt <= 1'b0;
         alarm_clear_input <= 1'b0;
         aux_input_7 <= 1'b0;
         aux_input_8 <= 1'b0;
      end
      else
      begin
         forward_run_input <= (active_mode == MODE_SPEED) &&
                              input_terminals[0];
         reverse_run_input <= (active_mode == MODE_SPEED) &&
                              input_terminals[1];
         positioning_start <= (active_mode == MODE_POS) &&
                              input_terminals[0];
         mechanical_origin_sensor <= (active_mode == MODE_POS) &&
                                     input_terminals[1];
         data_select <= (active_mode != MODE_NONE) ?
                        input_terminals[4:2] : 3'h0;
         current_cutoff <= (active_mode != MODE_NONE) &&
                           input_terminals[5];
         quick_halt <= (active_mode != MODE_NONE) && !protect_active &&
                       input_terminals[6];
         alarm_clear_input <= (active_mode != MODE_NONE) &&
                              protect_active && input_terminals[6];
         aux_input_7 <= cfg.in7_en && input_terminals[7];
         aux_input_8 <= cfg.in8_en && input_terminals[8];
      end
   end

   // Output terminals and encoder pulses
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         output_terminal_0 <= 1'b0;
         output_terminal_1 <= 1'b0;
         output_terminal_2 <= 1'b0;
         encoder_phase_a_output <= 1'b0;
         encoder_phase_b_output <= 1'b0;
      end
      else
      begin
         output_terminal_0 <= protect_active;
         if (protect_active)
            output_terminal_1 <= fault_code_pulse_in;
         else if (cfg.torque_sel)
            output_terminal_1 <= torque_reached_in;
         else
            output_terminal_1 <= busy_in;
         case (cfg.output_terminal_2_fn)
            AUX_BUSY: output_terminal_2 <= busy_in;
            AUX_TORQUE: output_terminal_2 <= torque_reached_in;
            AUX_FAULT: output_terminal_2 <= protect_active;
            default: output_terminal_2 <= 1'b0;
         endcase
         encoder_phase_a_output <= encoder_a_in;
         encoder_phase_b_output <= encoder_b_in;
      end
   end

   // Events: protection entry, alarm clear press, refused write
   always_comb
   begin
      next_irq_set = '0;
      next_irq_set[IRQ_PROTECT] = protect_active && !prot_d;
      next_irq_set[IRQ_CLEAR] = protect_active && input_terminals[6] &&
                                !in6_d;
      next_irq_set[IRQ_REJECT] = rej;
   end

   // Sticky status; a new event beats the read clear
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         prot_d <= 1'b0;
         in6_d <= 1'b0;
         irq_stat <= '0;
         irq <= 1'b0;
      end
      else
      begin
         prot_d <= protect_active;
         in6_d <= input_terminals[6];
         irq_stat <= (stat_rd ? '0 : irq_stat) | next_irq_set;
         irq <= |(irq_stat & irq_mask);
      end
   end

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence s_capture;
      !captured ##1 captured;
   endsequence

   property p_mode_hold;
      captured |=> $stable(active_mode);
   endproperty
   a_mode_hold: assert property (p_mode_hold)
      else $error("mode changed after capture");

   property p_speed_mode;
      (!captured && !mode_select_switch_a && mode_select_switch_b &&
       mode_select_switch_d) ##1 captured |-> active_mode == MODE_SPEED;
   endproperty
   a_speed_mode: assert property (p_speed_mode)
      else $error("speed mode not entered");

   property p_pos_mode;
      (!captured && mode_select_switch_a && mode_select_switch_b &&
       mode_select_switch_d) ##1 captured |-> active_mode == MODE_POS;
   endproperty
   a_pos_mode: assert property (p_pos_mode)
      else $error("position mode not entered");

   property p_stop_hold;
      active_mode == MODE_SPEED && cfg.stop_hold |=> stop_hold;
   endproperty
   a_stop_hold: assert property (p_stop_hold)
      else $error("servo lock not applied");

   property p_speed_range;
      motion_cmd.speed <= SPEED_DIG_MAX &&
      !(motion_cmd.speed > 12'h000 && motion_cmd.speed < SPEED_ANA_MIN &&
        $past(active_mode == MODE_SPEED && input_terminals[4:3] == 2'b00));
   endproperty
   a_speed_range: assert property (p_speed_range)
      else $error("speed setpoint out of range");

   property p_ramp_torque;
      motion_cmd.ramp <= RAMP_DIG_MAX && motion_cmd.torque <= TORQUE_MAX;
   endproperty
   a_ramp_torque: assert property (p_ramp_torque)
      else $error("ramp or torque out of range");

   property p_fwd_run;
      s_capture ##0 active_mode == MODE_SPEED ##1 1'b1 |=>
         forward_run_input == $past(input_terminals[0]);
   endproperty
   a_fwd_run: assert property (p_fwd_run)
      else $error("forward run not mapped");

   property p_alarm_clear;
      active_mode != MODE_NONE && protect_active && input_terminals[6]
         |=> alarm_clear_input && !quick_halt;
   endproperty
   a_alarm_clear: assert property (p_alarm_clear)
      else $error("terminal 6 not alarm clear");

   property p_code_out;
      protect_active |=> output_terminal_1 == $past(fault_code_pulse_in);
   endproperty
   a_code_out: assert property (p_code_out)
      else $error("output 1 not fault code");

   property p_torque_out;
      !protect_active && cfg.torque_sel
         |=> output_terminal_1 == $past(torque_reached_in);
   endproperty
   a_torque_out: assert property (p_torque_out)
      else $error("output 1 not torque reached");

   property p_pos_start;
      active_mode == MODE_POS |=> positioning_start ==
         $past(input_terminals[0]) && !forward_run_input;
   endproperty
   a_pos_start: assert property (p_pos_start)
      else $error("start not mapped");
endmodule

// [design/legacy_io_pkg.sv]
package legacy_io_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_CFG = 8'h04;
   localparam logic [7:0] OFS_SPEED = 8'h08;
   localparam logic [7:0] OFS_RAMP = 8'h0C;
   localparam logic [7:0] OFS_TORQUE = 8'h10;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
   localparam logic [7:0] OFS_INPUTS = 8'h1C;
   // Setpoint limits; speed in r/min, ramp in tenths of a second
   localparam logic [11:0] SPEED_ANA_MIN = 12'h01E;
   localparam logic [11:0] SPEED_ANA_MAX = 12'hBB8;
   localparam logic [11:0] SPEED_DIG_MAX = 12'hFA0;
   localparam logic [8:0] RAMP_ANA_MIN = 9'h001;
   localparam logic [8:0] RAMP_ANA_MAX = 9'h096;
   localparam logic [8:0] RAMP_DIG_MAX = 9'h12C;
   localparam logic [7:0] TORQUE_MAX = 8'hFA;
   // Values after reset
   localparam logic [11:0] SPEED_RST = 12'h000;
   localparam logic [8:0] RAMP_RST = 9'h001;
   localparam logic [7:0] TORQUE_RST = 8'h64;
   localparam logic [5:0] CFG_RST = 6'h00;
   localparam logic [2:0] MASK_RST = 3'h0;
   // Stop behaviour codes
   localparam logic STOP_FREE = 1'b0;
   localparam logic STOP_SERVO_LOCK = 1'b1;
   // Interrupt bit positions
   localparam int IRQ_PROTECT = 0;
   localparam int IRQ_CLEAR = 1;
   localparam int IRQ_REJECT = 2;
   localparam int IRQ_W = 3;

   typedef enum logic [1:0] {
      MODE_NONE = 2'b00,
      MODE_SPEED = 2'b01,
      MODE_POS = 2'b10
   } mode_t;

   typedef enum logic [1:0] {
      AUX_OFF = 2'b00,
      AUX_BUSY = 2'b01,
      AUX_TORQUE = 2'b10,
      AUX_FAULT = 2'b11
   } aux_fn_t;

   typedef struct packed {
      aux_fn_t output_terminal_2_fn;
      logic in8_en;
      logic in7_en;
      logic torque_sel;
      logic stop_hold;
   } cfg_t;

   typedef struct packed {
      logic [11:0] speed;
      logic [8:0] ramp;
      logic [7:0] torque;
   } cmd_t;
endpackage

// [verif/plc_model.sv]
`timescale 1ns/1ps
// Behavioural controller on the far side of the discrete terminals
module plc_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [8:0] want_terms, // Levels the sequence asks for
   input wire logic clear_on_fault, // Reacts to a fault when set
   input wire logic fault_seen, // Fault output read back
   output logic [8:0] input_terminals
);
   // Outputs move only after an edge, like a scan cycle of the controller
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         // Controller outputs are off while the driver powers up
         input_terminals <= 9'h000;
      end
      else
      begin
         // alarm clear request
         // Answers one scan late, never in the same cycle; one write only
         input_terminals <= want_terms |
                            {2'b00, clear_on_fault && fault_seen, 6'h00};
      end
   end
endmodule

// [verif/legacy_compat_io_mapping_tb.sv]
`timescale 1ns/1ps
module legacy_compat_io_mapping_tb;
   import legacy_io_pkg::*;
   // Bus master side
   logic hclk = 1'b0;
   logic hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'h2;
   logic hreadyout, hresp;
   // Switches start in speed position
   logic mode_select_switch_a = 1'b0;
   logic mode_select_switch_b = 1'b1, mode_select_switch_d = 1'b1;
   logic [8:0] input_terminals, want = 9'h000;
   logic clr = 1'b0, protect_active = 1'b0, busy_in = 1'b0;
   logic torque_reached_in = 1'b0, fault_code_pulse_in = 1'b0;
   logic encoder_a_in = 1'b0, encoder_b_in = 1'b0;
   logic [11:0] speed_pot_wiper_rpm = 12'h000;
   logic [8:0] ramp_pot_tenths = 9'h000;
   // Observed outputs
   mode_t active_mode;
   cmd_t motion_cmd;
   logic forward_run_input, reverse_run_input, positioning_start;
   logic mechanical_origin_sensor, current_cutoff, quick_halt;
   logic alarm_clear_input, aux_input_7, aux_input_8, stop_hold, irq;
   logic [2:0] data_select;
   logic output_terminal_0, output_terminal_1, output_terminal_2;
   logic encoder_phase_a_output, encoder_phase_b_output;
   // Bookkeeping; bus answers are sampled mid-cycle to avoid edge races
   int n_errors = 0;
   int compares = 0;
   int cycles = 0;
   logic rdy_q, rsp_q;
   logic [31:0] rd_q, rd;
   typedef struct {
      logic wr;
      logic [31:0] a;
      logic [31:0] w;
      logic [31:0] e;
   } row_t;
   // Reset values first, then writes with the value read back
   row_t rows [15] = '{
      '{1'b0, OFS_MODE, 32'h0, 32'h1},
      '{1'b0, OFS_SPEED, 32'h0, 32'h0},
      '{1'b0, OFS_RAMP, 32'h0, 32'h1},
      '{1'b0, OFS_TORQUE, 32'h0, 32'h64},
      '{1'b0, OFS_IRQ_MASK, 32'h0, 32'h0},
      '{1'b1, OFS_CFG, 32'h1, 32'h1}, // servo lock chosen
      '{1'b1, OFS_SPEED, 32'hFA0, 32'hFA0},
      '{1'b1, OFS_SPEED, 32'hFA1, 32'hFA0},
      '{1'b1, OFS_RAMP, 32'h12C, 32'h12C},
      '{1'b1, OFS_RAMP, 32'h12D, 32'h12C},
      '{1'b1, OFS_TORQUE, 32'hFA, 32'hFA},
      '{1'b1, OFS_TORQUE, 32'hFB, 32'hFA},
      '{1'b1, OFS_MODE, 32'h2, 32'h1},
      '{1'b1, OFS_IRQ_MASK, 32'h7, 32'h7},
      '{1'b1, 32'h100, 32'h55, 32'h0}
   };

   legacy_compat_io_mapping i_dut (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp,
      .mode_select_switch_a, .mode_select_switch_b, .mode_select_switch_d,
      .input_terminals, .protect_active, .busy_in, .torque_reached_in,
      .fault_code_pulse_in, .encoder_a_in, .encoder_b_in,
      .speed_pot_wiper_rpm, .ramp_pot_tenths, .active_mode,
      .forward_run_input, .reverse_run_input, .positioning_start,
      .mechanical_origin_sensor, .data_select, .current_cutoff,
      .quick_halt, .alarm_clear_input, .aux_input_7, .aux_input_8,
      .stop_hold, .motion_cmd, .output_terminal_0, .output_terminal_1,
      .output_terminal_2, .encoder_phase_a_output,
      .encoder_phase_b_output, .irq
   );

   plc_model i_plc (
      .hclk, .hresetn, .want_terms(want), .clear_on_fault(clr),
      .fault_seen(output_terminal_0), .input_terminals
   );

   // 50 MHz clock
   always #10 hclk = ~hclk;

   // Capture the bus answer before the edge that the master samples at
   always @(negedge hclk)
   begin
      rdy_q <= hreadyout;
      rsp_q <= hresp;
      rd_q <= hrdata;
   end

   // Hang guard; the whole run needs well under a thousand cycles
   always @(posedge hclk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_errors++;
         end_of_test();
      end
   end

   task automatic cmp(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One single word transfer; waits on ready, never on a fixed count
   task automatic xfer(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'b10;
      do @(posedge hclk); while (rdy_q !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (rdy_q !== 1'b1);
      rd = rd_q;
   endtask

   // Let partner and design registers both land, then look mid-cycle
   task automatic settle;
      repeat (3) @(posedge hclk);
      @(negedge hclk);
   endtask

   task automatic end_of_test;
      if (n_errors == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      mode_select_switch_a <= 1'b1;
      settle();
      cmp("active_mode", MODE_SPEED, active_mode);
      foreach (rows[i])
      begin
         if (rows[i].wr)
            xfer(1'b1, rows[i].a, rows[i].w);
         xfer(1'b0, rows[i].a, 32'h0);
         cmp("register", rows[i].e, rd);
         cmp("hresp", 32'h0, rsp_q);
      end
      settle();
      cmp("stop_hold", 32'h1, stop_hold);
      cmp("irq raised", 32'h1, irq);
      xfer(1'b0, OFS_IRQ_STAT, 32'h0);
      cmp("irq status", 32'h4, rd);
      // Refused event while its bit is masked must stay quiet
      xfer(1'b1, OFS_IRQ_MASK, 32'h3);
      xfer(1'b1, OFS_TORQUE, 32'hFF);
      settle();
      cmp("irq masked", 32'h0, irq);
      xfer(1'b0, OFS_IRQ_STAT, 32'h0);
      cmp("irq status", 32'h4, rd);
      @(posedge hclk);
      speed_pot_wiper_rpm <= 12'h014;
      settle();
      cmp("motion", {12'h000, 9'h001, 8'hFA}, motion_cmd);
      @(posedge hclk);
      speed_pot_wiper_rpm <= 12'hDAC;
      ramp_pot_tenths <= 9'h0C8;
      settle();
      cmp("motion", {12'hBB8, 9'h096, 8'hFA}, motion_cmd);
      @(posedge hclk);
      want <= 9'h008;
      settle();
      cmp("motion", {12'hFA0, 9'h12C, 8'hFA}, motion_cmd);
      @(posedge hclk);
      want <= 9'h077;
      busy_in <= 1'b1;
      encoder_a_in <= 1'b1;
      settle();
      cmp("inputs", 10'h3B8, {forward_run_input, reverse_run_input,
         data_select, current_cutoff, quick_halt, alarm_clear_input,
         positioning_start, mechanical_origin_sensor});
      cmp("outputs", 4'h6, {output_terminal_0, output_terminal_1,
         encoder_phase_a_output, encoder_phase_b_output});
      xfer(1'b0, OFS_INPUTS, 32'h0);
      cmp("input levels", 32'h077, rd);
      @(posedge hclk);
      want <= 9'h015;
      protect_active <= 1'b1;
      clr <= 1'b1;
      busy_in <= 1'b0;
      fault_code_pulse_in <= 1'b1;
      encoder_b_in <= 1'b1;
      settle();
      settle();
      cmp("halt swap", 2'b01, {quick_halt, alarm_clear_input});
      cmp("fault outs", 4'hF, {output_terminal_0, output_terminal_1,
         irq, encoder_phase_b_output});
      xfer(1'b0, OFS_IRQ_STAT, 32'h0);
      cmp("irq status", 32'h3, rd);
      settle();
      cmp("irq cleared", 32'h0, irq);
      @(posedge hclk);
      protect_active <= 1'b0;
      clr <= 1'b0;
      want <= 9'h180;
      torque_reached_in <= 1'b1;
      xfer(1'b1, OFS_CFG, 32'h2E);
      settle();
      cmp("assigned", 5'h1E, {output_terminal_1, output_terminal_2,
         aux_input_7, aux_input_8, stop_hold});
      // power up again in position control
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      want <= 9'h003;
      settle();
      cmp("active_mode", MODE_POS, active_mode);
      cmp("pos inputs", 4'hC, {positioning_start,
         mechanical_origin_sensor, forward_run_input,
         reverse_run_input});
      // Switch combination outside both modes leaves terminals unmapped
      @(posedge hclk);
      hresetn <= 1'b0;
      mode_select_switch_b <= 1'b0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      settle();
      cmp("active_mode", MODE_NONE, active_mode);
      cmp("none inputs", 4'h0, {positioning_start,
         mechanical_origin_sensor, forward_run_input,
         reverse_run_input});
      end_of_test();
   end
endmodule
